/* File: inc/ep_defines.svh */
// Purpose: Constants of the encoder position front end
// Assumes: Included by the design file only
// Notes: Offsets are APB byte addresses
`ifndef EP_DEFINES_SVH
`define EP_DEFINES_SVH
// Register byte offsets
`define EP_OFS_MODE 8'h00
`define EP_OFS_ERRDET 8'h04
`define EP_OFS_ETYPE 8'h08
`define EP_OFS_TBITS 8'h0c
`define EP_OFS_LINES 8'h10
`define EP_OFS_STRES 8'h14
`define EP_OFS_CTRL 8'h18
`define EP_OFS_STATUS 8'h1c
`define EP_OFS_TURNS 8'h20
`define EP_OFS_POS 8'h24
`define EP_OFS_FINE 8'h28
// Control bit positions
`define EP_CTRL_REINIT 0
`define EP_CTRL_TRIPRST 1
`define EP_CTRL_AUTOCFG 2
// Error detection enable bits
`define EP_ERR_WIRE 0
`define EP_ERR_PHASE 1
`define EP_ERR_POWER 2
// Reset values
`define EP_MODE_RST 2'h1
`define EP_ERRDET_RST 3'h0
`define EP_ETYPE_RST 4'h0
`define EP_TBITS_RST 5'h0c
`define EP_LINES_RST 16'h0400
`define EP_STRES_RST 6'h0d
// Encoder type codes
`define EP_TYPE_INC_MAX 4'h5
`define EP_TYPE_PLAIN_SC 4'h6
`define EP_TYPE_SC_RS485 4'h7
`define EP_TYPE_CRC_ONLY 4'h8
`define EP_TYPE_SC_CRC 4'h9
`define EP_TYPE_SYNC_ONLY 4'ha
`define EP_TYPE_SC_SYNC 4'hb
// Serial frame layout and check
`define EP_HDR_BITS 7'h02
`define EP_CRC_BITS 7'h05
`define EP_CRC_POLY 5'h09
`define EP_CRC_LIMIT 2'h3
`define EP_MAX_DATA 7'h20
`define EP_LINES_MIN 16'h0002
// Timing
`define EP_CLK_NS 100
`define EP_TRACK_NS 250000
`define EP_TRACK_CYC (`EP_TRACK_NS / `EP_CLK_NS)
`define EP_INIT_TIMEOUT_NS 20000000
`define EP_INIT_TIMEOUT_CYC (`EP_INIT_TIMEOUT_NS / `EP_CLK_NS)
`endif

/* File: inc/ep_pkg.sv */
// Purpose: Types of the encoder position front end
// Assumes: Nothing beyond the defines header
// Notes: One packed struct holds all state of the block
package ep_pkg;
   typedef enum logic [2:0] {EP_ST_INIT = 3'b001, EP_ST_RUN = 3'b010,
      EP_ST_FAIL = 3'b100} ep_state_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [1:0] mode;
      logic [2:0] errdet;
      logic [3:0] etype;
      logic [4:0] tbits;
      logic [15:0] lines;
      logic [5:0] stres;
      logic autocfg;
      logic [1:0] s_mode;
      logic [3:0] s_etype;
      logic [4:0] s_tbits;
      logic [5:0] s_stres;
      logic clk_s1, clk_s2, clk_s3;
      logic dat_s1, dat_s2;
      logic frm_s1, frm_s2, frm_s3;
      logic wb_s1, wb_s2, ph_s1, ph_s2;
      logic [31:0] shift;
      logic [6:0] bitcnt;
      logic [4:0] crc_calc;
      logic [4:0] crc_rx;
      logic pwr_bit, rot_bit, pwr_ok;
      ep_state_t st;
      logic [17:0] init_cnt;
      logic [1:0] crc_cnt;
      logic t_init, t_cksum, t_power, t_wire, t_phase, track_err;
      logic [15:0] turns, pos, fine;
      logic [31:0] win_ref;
      logic [11:0] win_cnt;
      logic trip, pos_valid, term_ab, term_z, term_uvw;
   } ep_state_s_t;
endpackage : ep_pkg

/* File: rtl/ep_encoder_if.sv */
// Purpose: Encoder position front end with APB register access
// Assumes: clock_in 10 MHz; link clock and data sampled as plain pins
// Notes: One state struct, registered once per clock
// Function
// R1 - Initialise at reset, trip reset, request
// R2 - Withhold position until init; fail trip
// R3 - Mode setting drives incremental terminations
// R4 - Plain sine/cosine ignores mode setting
// R5 - Rotary: turns field masks displayed turns
// R6 - Rotary: lines forced to power of two
// R7 - Rotary: resolution is single-turn bit count
// R8 - Linear: turns field is ratio, no mask
// R9 - Linear: resolution is whole position bits
// R10 - Comms-only absolute: outputs equal encoder value
// R11 - Few turns bits wrap at maximum position
// R12 - CRC failure keeps last valid position
// R13 - Sync serial format has no check
// R14 - Avoid absolute mode under six turns bits
// R15 - Delta mode accumulates sixteen turns bits
// R16 - Half turn per 250 us, else lost
// R17 - Three CRC errors trip; reset reinitialises
// R18 - Late powered encoder needs reinit request
// R19 - Power monitor trip holds until powered
// R20 - Auto-configuration sets mode from encoder
// R21 - Error enable bits gate trips
// R22 - Config applied between frames only
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "ep_defines.svh"

module ep_encoder_if #(
   parameter int INIT_TO_CYC = `EP_INIT_TIMEOUT_CYC
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic reset_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Encoder serial link pins
   input wire logic link_clk_in,
   input wire logic link_data_in,
   input wire logic link_frame_in,
   // Analogue front end detectors
   input wire logic wire_break_in,
   input wire logic phase_error_in,
   // Termination controls
   output logic term_ab_out,
   output logic term_z_out,
   output logic term_uvw_out,
   // Position result
   output logic pos_valid_out,
   output logic trip_out,
   output logic [15:0] turns_out,
   output logic [15:0] position_out
);
   import ep_pkg::*;

   ep_state_s_t q; // Registered state
   ep_state_s_t nxt_q; // Next state

   // Largest power of two not above v, at least two
   function automatic logic [15:0] pow2_floor(input logic [15:0] v);
      logic [15:0] r;
      r = `EP_LINES_MIN;
      for (int i = 1; i < 16; i++)
      begin
         if (v[i])
            r = 16'h0001 << i;
      end
      return r;
   endfunction : pow2_floor

   // Mask of n low bits, n up to 32
   function automatic logic [31:0] low_mask(input logic [6:0] n);
      logic [32:0] m;
      m = (33'h000000001 << n) - 33'h000000001;
      return m[31:0];
   endfunction : low_mask

   // Decode helpers of the live and shadow configuration
   logic live_rotary; // Live mode gives rotary interpretation
   logic sh_comms; // Shadow type uses the serial link
   logic sh_crc; // Shadow type carries a CRC
   logic sh_conly; // Shadow type is comms-only
   logic sh_rotary; // Shadow config is rotary
   logic [6:0] nbits; // Data bits per frame
   logic [6:0] exp_len; // Expected frame length
   logic link_rise; // Link clock rising edge
   logic frm_rise, frm_fall; // Frame boundaries
   logic frame_ok; // Frame passed length and check
   logic [31:0] raw; // Received data, right aligned
   logic [31:0] single; // Single-turn part
   logic [31:0] turns_raw; // Turns part
   logic [31:0] left; // Single-turn part, left aligned
   logic [15:0] n_turns, n_pos, n_fine; // Decoded position
   logic [15:0] dpos; // Delta of position word
   logic [31:0] acc; // Tracked position after delta
   logic [31:0] wdiff; // Movement inside the window
   logic fb; // CRC feedback bit
   logic reinit; // Start a new initialisation
   logic wr, rd; // APB write commit, read setup

   // Whole next-state logic
   always_comb
   begin
      nxt_q = q;
      live_rotary = 1'b0;
      sh_comms = 1'b0;
      sh_crc = 1'b0;
      sh_conly = 1'b0;
      sh_rotary = 1'b0;
      nbits = 7'h00;
      exp_len = 7'h00;
      frame_ok = 1'b0;
      raw = 32'h00000000;
      single = 32'h00000000;
      turns_raw = 32'h00000000;
      left = 32'h00000000;
      n_turns = 16'h0000;
      n_pos = 16'h0000;
      n_fine = 16'h0000;
      dpos = 16'h0000;
      acc = 32'h00000000;
      wdiff = 32'h00000000;
      fb = 1'b0;
      reinit = 1'b0;

      // Two-flop synchronisers for the link and detector pin inputs
      nxt_q.clk_s1 = link_clk_in;
      nxt_q.clk_s2 = q.clk_s1;
      nxt_q.clk_s3 = q.clk_s2;
      nxt_q.dat_s1 = link_data_in;
      nxt_q.dat_s2 = q.dat_s1;
      nxt_q.frm_s1 = link_frame_in;
      nxt_q.frm_s2 = q.frm_s1;
      nxt_q.frm_s3 = q.frm_s2;
      nxt_q.wb_s1 = wire_break_in;
      nxt_q.wb_s2 = q.wb_s1;
      nxt_q.ph_s1 = phase_error_in;
      nxt_q.ph_s2 = q.ph_s1;
      link_rise = q.clk_s2 & ~q.clk_s3;
      frm_rise = q.frm_s2 & ~q.frm_s3;
      frm_fall = q.frm_s3 & ~q.frm_s2;

      // Shadow decode; plain sine/cosine never looks at the mode
      sh_comms = (q.s_etype >= `EP_TYPE_SC_RS485) && (q.s_etype <= `EP_TYPE_SC_SYNC);
      sh_crc = (q.s_etype == `EP_TYPE_SC_RS485) || (q.s_etype == `EP_TYPE_CRC_ONLY)
         || (q.s_etype == `EP_TYPE_SC_CRC);
      sh_conly = (q.s_etype == `EP_TYPE_CRC_ONLY) || (q.s_etype == `EP_TYPE_SYNC_ONLY);
      sh_rotary = sh_comms && (q.s_mode != 2'h0); // R4
      live_rotary = (q.etype >= `EP_TYPE_SC_RS485) && (q.etype <= `EP_TYPE_SC_SYNC)
         && (q.mode != 2'h0);

      // Rotary sums both fields; linear uses the resolution alone
      if (sh_rotary)
         nbits = {2'b00, q.s_tbits} + {1'b0, q.s_stres}; // R7
      else
         nbits = {1'b0, q.s_stres}; // R9
      if (nbits > `EP_MAX_DATA)
         nbits = `EP_MAX_DATA;
      exp_len = `EP_HDR_BITS + nbits + (sh_crc ? `EP_CRC_BITS : 7'h00);

      // Config only moves into the shadow outside a frame
      if (!q.frm_s2 && !frm_fall)
      begin
         nxt_q.s_mode = q.mode; // R22
         nxt_q.s_etype = q.etype;
         nxt_q.s_tbits = q.tbits;
         nxt_q.s_stres = q.stres;
      end

      // Serial receive: power bit, rotary flag, data, then CRC
      if (frm_rise)
      begin
         nxt_q.bitcnt = 7'h00;
         nxt_q.shift = 32'h00000000;
         nxt_q.crc_calc = 5'h00;
         nxt_q.crc_rx = 5'h00;
      end
      else if (q.frm_s2 && link_rise)
      begin
         if (q.bitcnt == 7'h00)
            nxt_q.pwr_bit = q.dat_s2;
         else if (q.bitcnt == 7'h01)
            nxt_q.rot_bit = q.dat_s2;
         else if (q.bitcnt < `EP_HDR_BITS + nbits)
         begin
            nxt_q.shift = {q.shift[30:0], q.dat_s2};
            fb = q.dat_s2 ^ q.crc_calc[4];
            nxt_q.crc_calc = {q.crc_calc[3:0], 1'b0} ^ (fb ? `EP_CRC_POLY : 5'h00);
         end
         else
            nxt_q.crc_rx = {q.crc_rx[3:0], q.dat_s2};
         if (q.bitcnt != 7'h7f)
            nxt_q.bitcnt = q.bitcnt + 7'h01;
      end

      // Sync serial frames get no integrity check
      frame_ok = (q.bitcnt == exp_len) && (!sh_crc || (q.crc_rx == q.crc_calc)); // R13

      // Decode the received word
      raw = q.shift & low_mask(nbits);
      single = raw & low_mask({1'b0, q.s_stres});
      turns_raw = raw >> q.s_stres;
      left = single << (6'd32 - q.s_stres);
      if (sh_rotary)
      begin
         // Turns masked to the encoder's turns bits; wraps at its maximum
         n_turns = turns_raw[15:0] & 16'(low_mask({2'b00, q.s_tbits})); // R5 R11 R14
         n_pos = left[31:16]; // R10
         n_fine = left[15:0];
      end
      else
      begin
         // Whole position value, no turns mask
         n_turns = raw[31:16]; // R8
         n_pos = raw[15:0];
         n_fine = 16'h0000;
      end

      // APB: answer in the first access cycle
      wr = psel_in & penable_in & q.pready & pwrite_in;
      rd = psel_in & ~penable_in;
      nxt_q.pready = rd;
      if (rd)
      begin
         nxt_q.pslverr = 1'b0;
         nxt_q.prdata = 32'h00000000;
         if (paddr_in == `EP_OFS_MODE)
            nxt_q.prdata[1:0] = q.mode;
         else if (paddr_in == `EP_OFS_ERRDET)
            nxt_q.prdata[2:0] = q.errdet;
         else if (paddr_in == `EP_OFS_ETYPE)
            nxt_q.prdata[3:0] = q.etype;
         else if (paddr_in == `EP_OFS_TBITS)
            nxt_q.prdata[4:0] = q.tbits;
         else if (paddr_in == `EP_OFS_LINES)
            nxt_q.prdata[15:0] = q.lines;
         else if (paddr_in == `EP_OFS_STRES)
            nxt_q.prdata[5:0] = q.stres;
         else if (paddr_in == `EP_OFS_CTRL)
            nxt_q.prdata[`EP_CTRL_AUTOCFG] = q.autocfg;
         else if (paddr_in == `EP_OFS_STATUS)
            nxt_q.prdata[9:0] = {q.crc_cnt, q.pwr_ok, q.track_err, q.t_phase, q.t_wire,
               q.t_power, q.t_cksum, q.t_init, (q.st == EP_ST_RUN)};
         else if (paddr_in == `EP_OFS_TURNS)
            nxt_q.prdata[15:0] = q.turns;
         else if (paddr_in == `EP_OFS_POS)
            nxt_q.prdata[15:0] = q.pos;
         else if (paddr_in == `EP_OFS_FINE)
            nxt_q.prdata[15:0] = q.fine;
         else
            nxt_q.pslverr = 1'b1; // Unmapped address
      end
      else if (!psel_in)
         nxt_q.pslverr = 1'b0;

      // Register writes; out-of-range values are dropped
      if (wr)
      begin
         if (paddr_in == `EP_OFS_MODE)
         begin
            if (pwdata_in[1:0] != 2'h3)
               nxt_q.mode = pwdata_in[1:0];
         end
         else if (paddr_in == `EP_OFS_ERRDET)
            nxt_q.errdet = pwdata_in[2:0];
         else if (paddr_in == `EP_OFS_ETYPE)
         begin
            if (pwdata_in[3:0] <= `EP_TYPE_SC_SYNC)
               nxt_q.etype = pwdata_in[3:0];
         end
         else if (paddr_in == `EP_OFS_TBITS)
            nxt_q.tbits = pwdata_in[4:0];
         else if (paddr_in == `EP_OFS_LINES)
            nxt_q.lines = pwdata_in[15:0];
         else if (paddr_in == `EP_OFS_STRES)
            nxt_q.stres = pwdata_in[5:0];
         else if (paddr_in == `EP_OFS_CTRL)
         begin
            nxt_q.autocfg = pwdata_in[`EP_CTRL_AUTOCFG];
            if (pwdata_in[`EP_CTRL_REINIT])
               reinit = 1'b1; // R1 R18
            if (pwdata_in[`EP_CTRL_TRIPRST])
            begin
               // Trip reset clears and reinitialises
               reinit = 1'b1; // R17
               nxt_q.t_init = 1'b0;
               nxt_q.t_cksum = 1'b0;
               nxt_q.t_wire = 1'b0;
               nxt_q.t_phase = 1'b0;
               if (q.pwr_ok)
                  nxt_q.t_power = 1'b0; // R19
            end
         end
      end

      // Rotary lines per revolution are kept a power of two
      if (live_rotary)
         nxt_q.lines = pow2_floor(nxt_q.lines); // R6

      // Terminations: only incremental types follow the mode
      if (q.etype <= `EP_TYPE_INC_MAX)
      begin
         nxt_q.term_ab = (q.mode != 2'h0); // R3
         nxt_q.term_z = (q.mode == 2'h2);
      end
      else
      begin
         nxt_q.term_ab = 1'b1;
         nxt_q.term_z = 1'b1;
      end
      nxt_q.term_uvw = 1'b1;

      // Tracking window restarts every 250 us
      if (q.win_cnt == 12'(`EP_TRACK_CYC - 1))
      begin
         nxt_q.win_cnt = 12'h000;
         nxt_q.win_ref = {q.turns, q.pos};
      end
      else
         nxt_q.win_cnt = q.win_cnt + 12'h001;

      // Initialisation and run sequence
      case (q.st)
         EP_ST_INIT:
         begin
            if (!sh_comms)
               nxt_q.st = EP_ST_RUN; // No serial position to read
            else if (frm_fall && frame_ok)
            begin
               nxt_q.turns = n_turns;
               nxt_q.pos = n_pos;
               nxt_q.fine = n_fine;
               nxt_q.win_ref = {n_turns, n_pos};
               nxt_q.win_cnt = 12'h000;
               nxt_q.st = EP_ST_RUN;
               if (q.autocfg && sh_crc)
                  nxt_q.mode = q.rot_bit ? 2'h1 : 2'h0; // R20
            end
            else if (frm_fall || (q.init_cnt == 18'(INIT_TO_CYC - 1)))
            begin
               nxt_q.t_init = 1'b1; // R2
               nxt_q.st = EP_ST_FAIL;
            end
            else
               nxt_q.init_cnt = q.init_cnt + 18'h00001;
         end
         EP_ST_RUN:
         begin
            if (sh_comms && frm_fall && frame_ok)
            begin
               nxt_q.crc_cnt = 2'h0;
               if (sh_conly && (q.s_mode == 2'h0))
               begin
                  // Accumulate change; turns grow to 16 bits without jumps
                  dpos = n_pos - q.pos;
                  acc = {q.turns, q.pos} + {{16{dpos[15]}}, dpos}; // R15
                  nxt_q.turns = acc[31:16];
                  nxt_q.pos = acc[15:0];
                  wdiff = acc - q.win_ref;
                  if ((wdiff[31] ? (32'h00000000 - wdiff) : wdiff) >= 32'h00008000)
                     nxt_q.track_err = 1'b1; // R16
               end
               else
               begin
                  nxt_q.turns = n_turns; // R10
                  nxt_q.pos = n_pos;
               end
               nxt_q.fine = n_fine;
            end
            else if (sh_crc && frm_fall)
            begin
               // Bad frame keeps the last good position
               if (q.crc_cnt == `EP_CRC_LIMIT - 2'h1)
                  nxt_q.t_cksum = 1'b1; // R17
               else
                  nxt_q.crc_cnt = q.crc_cnt + 2'h1; // R12
            end
         end
         EP_ST_FAIL:
         begin
            nxt_q.st = EP_ST_FAIL; // Left only by a new initialisation
         end
         default:
         begin
            nxt_q.st = EP_ST_INIT;
         end
      endcase

      // Power status from every frame, gated by its enable
      if (sh_comms && frm_fall)
      begin
         nxt_q.pwr_ok = q.pwr_bit;
         if (q.errdet[`EP_ERR_POWER] && !q.pwr_bit)
            nxt_q.t_power = 1'b1; // R19 R21
      end
      if (q.errdet[`EP_ERR_WIRE] && q.wb_s2)
         nxt_q.t_wire = 1'b1; // R21
      if (q.errdet[`EP_ERR_PHASE] && q.ph_s2)
         nxt_q.t_phase = 1'b1; // R21

      // New initialisation; the trip sets above still win
      if (reinit)
      begin
         nxt_q.st = EP_ST_INIT; // R1
         nxt_q.init_cnt = 18'h00000;
         nxt_q.crc_cnt = 2'h0;
         nxt_q.track_err = 1'b0;
      end

      // Registered outputs; position withheld until initialised
      nxt_q.trip = nxt_q.t_init | nxt_q.t_cksum | nxt_q.t_power | nxt_q.t_wire
         | nxt_q.t_phase;
      nxt_q.pos_valid = (nxt_q.st == EP_ST_RUN) && !nxt_q.trip; // R2
   end

   // State register; reset starts an initialisation
   always_ff @(posedge clock_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         q <= '0;
         q.st <= EP_ST_INIT; // R1
         q.mode <= `EP_MODE_RST;
         q.errdet <= `EP_ERRDET_RST;
         q.etype <= `EP_ETYPE_RST;
         q.tbits <= `EP_TBITS_RST;
         q.lines <= `EP_LINES_RST;
         q.stres <= `EP_STRES_RST;
         q.s_mode <= `EP_MODE_RST;
         q.s_etype <= `EP_ETYPE_RST;
         q.s_tbits <= `EP_TBITS_RST;
         q.s_stres <= `EP_STRES_RST;
         q.term_uvw <= 1'b1;
      end
      else
         q <= nxt_q;
   end

   // Outputs straight from the state register
   assign prdata_out = q.prdata;
   assign pready_out = q.pready;
   assign pslverr_out = q.pslverr;
   assign term_ab_out = q.term_ab;
   assign term_z_out = q.term_z;
   assign term_uvw_out = q.term_uvw;
   assign pos_valid_out = q.pos_valid;
   assign trip_out = q.trip;
   assign turns_out = q.turns;
   assign position_out = q.pos;
endmodule : ep_encoder_if
`default_nettype wire

/* File: tb/encoder_position_interface_tb.sv */
// Purpose: Self-checking bench of the encoder position front end
// Assumes: APB master tasks and a link model drive the design
// Notes: Read results checked against a queue of expectations
`timescale 1ns/1ns
`default_nettype none
module encoder_position_interface_tb;
   // Design pins
   logic clock_in = 1'b0, reset_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   logic [7:0] paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0, prdata_out;
   logic wire_break_in = 1'b0, phase_error_in = 1'b0;
   logic pready_out, pslverr_out, term_ab_out, term_z_out, term_uvw_out, pos_valid_out, trip_out;
   logic [15:0] turns_out, position_out;
   wire logic link_clk_in, link_data_in, link_frame_in;
   // Bench state
   int n_mismatch = 0, checks = 0, seed = 32'h51bd31ba;
   logic [31:0] expq[$];
   logic [31:0] d;
   logic [31:0] rv[7] = '{32'h1, 32'h0, 32'h0, 32'hc, 32'h400, 32'hd, 32'h0};
   always #50 clock_in = ~clock_in;
   // Short init timeout keeps the run brief
   ep_encoder_if #(.INIT_TO_CYC(2000)) DUT (.*);
   ep_link_model link (.link_clk_out(link_clk_in), .link_data_out(link_data_in),
      .link_frame_out(link_frame_in));
   task chk(input bit ok, input string m);
      checks++;
      if (!ok)
      begin
         n_mismatch++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk
   task give_verdict;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict
   // One APB transfer, held until ready is seen
   task apb(input bit w, input logic [7:0] a, input logic [31:0] v);
      int k;
      @(posedge clock_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= v;
      @(posedge clock_in);
      penable_in <= 1'b1;
      k = 0;
      // Ready is sampled at the rising edge that commits the transfer
      @(posedge clock_in);
      while (pready_out !== 1'b1 && k < 20)
      begin
         @(posedge clock_in);
         k++;
      end
      if (k == 20)
      begin
         n_mismatch++;
         give_verdict();
      end
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] v);
      apb(1'b1, a, v);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e);
      expq.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask : rd
   // Frame, then room for sync and update
   task fr(input logic [31:0] v, input int n, input bit crc, input bit bad, input bit pwr);
      link.send(v, n, crc, bad, pwr);
      repeat (8) @(posedge clock_in);
   endtask : fr
   task settle;
      repeat (4) @(negedge clock_in);
   endtask : settle
   // Read results against the oldest expectation
   always @(negedge clock_in)
      if (psel_in && penable_in && pready_out === 1'b1 && !pwrite_in)
      begin
         chk(expq.size() > 0 && prdata_out === expq[0], "read data");
         if (expq.size() > 0)
            void'(expq.pop_front());
      end
   initial
   begin
      repeat (2) @(posedge clock_in);
      reset_in <= 1'b0;
      foreach (rv[i])
         rd(8'(4 * i), rv[i]);
      rd(8'h40, 32'h0);
      $display("test reset done");
      for (int m = 0; m < 3; m++)
      begin
         wr(8'h00, 32'(m));
         settle();
         chk(term_ab_out === (m > 0) && term_z_out === (m == 2), "term");
      end
      wr(8'h00, 32'h3);
      rd(8'h00, 32'h2);
      wr(8'h08, 32'h6);
      wr(8'h00, 32'h0);
      settle();
      chk(term_ab_out === 1'b1 && term_z_out === 1'b1, "plain term");
      for (int b = 0; b < 2; b++)
      begin
         @(posedge clock_in);
         {phase_error_in, wire_break_in} <= 2'(1 << b);
         settle();
         chk(trip_out === 1'b0, "ungated");
         wr(8'h04, 32'(1 << b));
         settle();
         chk(trip_out === 1'b1, "no trip");
         @(posedge clock_in);
         {phase_error_in, wire_break_in} <= 2'h0;
         wr(8'h18, 32'h2);
         wr(8'h04, 32'h0);
         settle();
         chk(trip_out === 1'b0, "trip stuck");
      end
      $display("test terminations done");
      // Rotary absolute: 4 turns bits, 8 single-turn bits
      wr(8'h08, 32'h8);
      wr(8'h00, 32'h1);
      wr(8'h0c, 32'h4);
      wr(8'h14, 32'h8);
      wr(8'h18, 32'h1);
      wr(8'h10, 32'h1);
      rd(8'h10, 32'h2);
      wr(8'h10, 32'hffff);
      rd(8'h10, 32'h8000);
      chk(pos_valid_out === 1'b0, "valid early");
      d = 32'($random(seed)) & 32'hfff;
      fr(d, 12, 1, 0, 1);
      rd(8'h20, 32'(d[11:8]));
      rd(8'h24, 32'({d[7:0], 8'h00}));
      rd(8'h28, 32'h0);
      for (int k = 0; k < 3; k++)
      begin
         fr(~d, 12, 1, 1, 1);
         rd(8'h24, 32'({d[7:0], 8'h00}));
      end
      chk(trip_out === 1'b1, "no crc trip");
      wr(8'h18, 32'h2);
      fr(~d, 12, 1, 0, 1);
      rd(8'h20, {28'h0000000, ~d[11:8]});
      chk(trip_out === 1'b0 && pos_valid_out === 1'b1, "no reinit");
      $display("test rotary done");
      // Linear sync serial: 20 bits of whole position
      wr(8'h08, 32'hb);
      wr(8'h00, 32'h0);
      wr(8'h14, 32'h14);
      wr(8'h10, 32'h3e8);
      rd(8'h10, 32'h3e8);
      fr(32'h31234, 20, 0, 0, 1);
      rd(8'h20, 32'h3);
      rd(8'h24, 32'h1234);
      // Delta tracking across a position wrap
      wr(8'h08, 32'ha);
      wr(8'h14, 32'h10);
      wr(8'h18, 32'h1);
      fr(32'hf000, 16, 0, 0, 1);
      fr(32'h1000, 16, 0, 0, 1);
      rd(8'h20, 32'h1);
      rd(8'h24, 32'h1000);
      $display("test linear done");
      // Power monitor holds the trip until power is reported
      wr(8'h04, 32'h4);
      fr(32'h1000, 16, 0, 0, 0);
      wr(8'h18, 32'h2);
      settle();
      chk(trip_out === 1'b1, "power trip");
      fr(32'h1000, 16, 0, 0, 1);
      wr(8'h18, 32'h2);
      fr(32'h1000, 16, 0, 0, 1);
      settle();
      chk(trip_out === 1'b0, "power stuck");
      $display("test power done");
      give_verdict();
   end
endmodule : encoder_position_interface_tb
`default_nettype wire

/* File: tb/ep_encoder_if_properties.sv */
// Purpose: Port checker of the encoder position front end
// Assumes: Bound to ep_encoder_if, sees its ports only
// Notes: One clock domain, reset disables all properties
`timescale 1ns/1ns
`default_nettype none
module ep_encoder_if_properties (
   // All ports of the front end
   input wire logic clock_in, reset_in, psel_in, penable_in, pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in, prdata_out,
   input wire logic pready_out, pslverr_out, link_clk_in, link_data_in, link_frame_in,
   input wire logic wire_break_in, phase_error_in, term_ab_out, term_z_out, term_uvw_out,
   input wire logic pos_valid_out, trip_out,
   input wire logic [15:0] turns_out, position_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (reset_in);
   // Zero wait states: answer one cycle after setup
   apb_answer_a: assert property (psel_in && !penable_in |=> pready_out)
      else $error("no ready after setup");
   ready_pulse_a: assert property (pready_out |=> !pready_out)
      else $error("ready held too long");
   unmapped_err_a: assert property (pready_out && !pwrite_in && paddr_in > 8'h28
      |-> pslverr_out && prdata_out == 32'h0) else $error("unmapped read accepted");
   uvw_on_a: assert property (term_uvw_out) else $error("uvw termination off");
   z_needs_ab_a: assert property (term_z_out |-> term_ab_out)
      else $error("marker on without quadrature");
   // Valid and trip leave one register together
   valid_no_trip_a: assert property (trip_out |-> !pos_valid_out)
      else $error("position valid while tripped");
   pos_hold_a: assert property ((!link_frame_in && !psel_in) [*8]
      |=> $stable(position_out) && $stable(turns_out)) else $error("position moved idle");
   trip_sticky_a: assert property ((trip_out && !psel_in) [*3] |=> trip_out)
      else $error("trip cleared without reset");
   cover property ($rose(trip_out));
   cover property (pslverr_out);
   cover property ($rose(pos_valid_out));
endmodule : ep_encoder_if_properties
bind ep_encoder_if ep_encoder_if_properties u_props (.*);
`default_nettype wire

/* File: tb/ep_link_model.sv */
// Purpose: Behavioural serial position encoder at the link's far side
// Assumes: Frame high around the bits, data taken on clock rise
// Notes: Link clock stands still low between frames
`timescale 1ns/1ns
`default_nettype none
module ep_link_model (
   // Link pins
   output logic link_clk_out,
   output logic link_data_out,
   output logic link_frame_out
);
   // Idle link
   initial
   begin
      link_clk_out = 1'b0;
      link_data_out = 1'b1;
      link_frame_out = 1'b0;
   end
   // One bit, 800 ns link period
   task put(input logic b);
      link_data_out = b;
      #400 link_clk_out = 1'b1;
      #400 link_clk_out = 1'b0;
   endtask : put
   // Bench keeps turns below the wrap with few turns bits
   task send(input logic [31:0] d, input int n, input bit crc, input bit bad, input bit pwr);
      logic [4:0] c;
      logic fb;
      c = 5'h00;
      // Keep link edges away from the block's clock edges
      #20;
      link_frame_out = 1'b1;
      #400;
      put(pwr);
      put(1'b1);
      for (int i = n - 1; i >= 0; i--)
      begin
         put(d[i]);
         fb = d[i] ^ c[4];
         c = {c[3:0], 1'b0} ^ (fb ? 5'h09 : 5'h00);
      end
      // Check field only on crc formats, spoilt on request
      c[0] = c[0] ^ bad;
      for (int i = 4; i >= 0 && crc; i--)
         put(c[i]);
      // Released data no longer shows its last bit
      link_data_out = ~link_data_out;
      link_frame_out = 1'b0;
      #800;
   endtask : send
endmodule : ep_link_model
`default_nettype wire
